/* File: ahb_host_model.sv */
// Bus master standing in for the host controller
`timescale 1ns/10ps
module ahb_host_model (
  // Clock
  input wire logic core_clk,
  // Request
  output logic hsel,
  output logic [11:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // Answer
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Waits on ready with no assumed latency; only the bench timeout ends it
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [31:0] wd,
      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
endmodule

/* File: low_pulse_timer.sv */
// Timer that holds an active-low pin low for a loaded number of cycles
`timescale 1ns/10ps
module low_pulse_timer #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Trigger
  input wire logic start,
  input wire logic [W-1:0] lengthCycles,
  // Pin
  output logic pinLowN
);
  logic [W-1:0] count_reg;

  // Retrigger restarts the width, so a fast rate keeps the pin low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_reg <= '0;
      pinLowN <= 1'b1;
    end else if (start) begin
      count_reg <= lengthCycles - 1'b1;
      pinLowN <= 1'b0;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end else begin
      pinLowN <= 1'b1;
    end
  end
endmodule

/* File: rate_code_decoder.sv */
// Decoder from one rate nibble to output period, averaging count and start kind
`timescale 1ns/10ps
`include "sample_rate_decimation_defs.svh"
module rate_code_decoder #(
  parameter int CODE_W = 4,
  parameter int IDLE_W = 12,
  parameter int MAX_SHIFT = 12
) (
  // Setting
  input wire logic [CODE_W-1:0] code,
  input wire logic [1:0] powerSelect,
  input wire logic [IDLE_W-1:0] idleTime,
  // Decoded
  output logic [IDLE_W+MAX_SHIFT:0] periodTicks,
  output logic [MAX_SHIFT:0] averagingCount,
  output logic fastStart
);
  logic [CODE_W-1:0] shift;
  logic [IDLE_W+MAX_SHIFT:0] idleUnits;

  always_comb begin
    shift = (code > CODE_W'(MAX_SHIFT)) ? CODE_W'(MAX_SHIFT) : code;
    idleUnits = (IDLE_W + MAX_SHIFT + 1)'(idleTime) + 1'b1;
    if (powerSelect == `PM_LOW) begin
      periodTicks = (IDLE_W + MAX_SHIFT + 1)'(1) << shift;
      averagingCount = (MAX_SHIFT + 1)'(1);
      fastStart = (code == '0);
    end else if (powerSelect == `PM_HIGH) begin
      periodTicks = (IDLE_W + MAX_SHIFT + 1)'(1) << shift;
      averagingCount = (MAX_SHIFT + 1)'(1) << shift;
      fastStart = (code == '0);
    end else begin
      periodTicks = idleUnits << shift;
      averagingCount = (MAX_SHIFT + 1)'(1) << shift;
      fastStart = (idleTime == '0);
    end
  end
endmodule

/* File: sample_rate_decimation_ctrl.sv */
// Output rate and averaging control with its register file on AHB-Lite
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "sample_rate_decimation_defs.svh"

module sample_rate_decimation_ctrl #(
  parameter int ADDR_W = 12,
  parameter int IDLE_W = 12,
  parameter int MAX_SHIFT = 12,
  parameter int unsigned TICK_CYC = `SAMPLE_TICK_CYC,
  parameter int unsigned FIRST_CYC = `FIRST_DELAY_CYC,
  parameter int unsigned SETTLE_CYC = `SETTLE_STEP_CYC,
  parameter int unsigned GAP_CYC = `SWITCH_GAP_CYC,
  parameter int unsigned PULSE_CYC = `PULSE_WIDTH_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Device pins and state
  input wire logic bootModePin,
  input wire logic sleepRequest,
  // Sample engine
  output logic sampleStrobe,
  output logic [MAX_SHIFT:0] averagingCount,
  output logic inSleepState,
  // Interrupts
  output logic firstInterruptPinN,
  output logic irq
);
  localparam int PERIOD_W = IDLE_W + MAX_SHIFT + 1;
  localparam int IDX_W = ADDR_W - 2;

  sample_rate_decimation_pkg::engine_state_t state_reg;
  logic wrPend_reg;
  logic rdPend_reg;
  logic [IDX_W-1:0] addrIdx_reg;
  logic [7:0] rateCfg_reg;
  logic [`CTRL_W-1:0] ctrl_reg;
  logic [IDLE_W-1:0] awakeIdle_reg;
  logic [IDLE_W-1:0] sleepIdle_reg;
  logic [`IRQ_W-1:0] irqStatus_reg;
  logic [`IRQ_W-1:0] irqMask_reg;
  logic bootLatched_reg;
  logic [31:0] cycLeft_reg;
  logic [PERIOD_W-1:0] unitsLeft_reg;
  logic switchDone;
  logic [31:0] readValue;
  logic addrPhase;
  logic cfgLocked;
  logic active;
  logic tick;
  logic [PERIOD_W-1:0] awakePeriod;
  logic [PERIOD_W-1:0] sleepPeriod;
  logic [PERIOD_W-1:0] selPeriod;
  logic [MAX_SHIFT:0] awakeAvg;
  logic [MAX_SHIFT:0] sleepAvg;
  logic [MAX_SHIFT:0] selAvg;
  logic awakeFast;
  logic sleepFast;
  logic selFast;
  logic [IDLE_W-1:0] awakeIdleReg;
  logic [IDLE_W-1:0] sleepIdleReg;

  assign addrPhase = hsel && htrans[1] && hready;
  assign active = ctrl_reg[`CTRL_ACTIVE];
  assign cfgLocked = active || ctrl_reg[`CTRL_SECOND_PIN_FUNC];
  assign tick = (cycLeft_reg == 32'h0000_0000);
  assign awakeIdleReg = awakeIdle_reg;
  assign sleepIdleReg = sleepIdle_reg;

  rate_code_decoder #(
    .CODE_W(4),
    .IDLE_W(IDLE_W),
    .MAX_SHIFT(MAX_SHIFT)
  ) awakeDecode (
    .code(rateCfg_reg[`CFG_AWAKE_MSB:`CFG_AWAKE_LSB]),
    .powerSelect(ctrl_reg[`CTRL_AWAKE_PM_LSB +: 2]),
    .idleTime(awakeIdleReg),
    .periodTicks(awakePeriod),
    .averagingCount(awakeAvg),
    .fastStart(awakeFast)
  );

  rate_code_decoder #(
    .CODE_W(4),
    .IDLE_W(IDLE_W),
    .MAX_SHIFT(MAX_SHIFT)
  ) sleepDecode (
    .code(rateCfg_reg[`CFG_SLEEP_MSB:`CFG_SLEEP_LSB]),
    .powerSelect(ctrl_reg[`CTRL_SLEEP_POWER_SELECT_LSB +: 2]),
    .idleTime(sleepIdleReg),
    .periodTicks(sleepPeriod),
    .averagingCount(sleepAvg),
    .fastStart(sleepFast)
  );

  always_comb begin
    if (inSleepState) begin
      selPeriod = sleepPeriod;
      selAvg = sleepAvg;
      selFast = sleepFast;
    end else begin
      selPeriod = awakePeriod;
      selAvg = awakeAvg;
      selFast = awakeFast;
    end
  end

  // Bus phases; reads take one wait state so a just-written value reads back
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrPend_reg <= 1'b0;
      rdPend_reg <= 1'b0;
      addrIdx_reg <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wrPend_reg <= addrPhase && hwrite;
      rdPend_reg <= addrPhase && !hwrite;
      hreadyout <= !(addrPhase && !hwrite);
      hresp <= 1'b0;
      if (addrPhase) begin
        addrIdx_reg <= haddr[ADDR_W-1:2];
      end
    end
  end

  always_comb begin
    case (addrIdx_reg)
      IDX_W'(`IDX_RATE_CFG): readValue = {24'h000000, rateCfg_reg};
      IDX_W'(`IDX_CTRL): readValue = {25'h0000000, ctrl_reg};
      IDX_W'(`IDX_AWAKE_IDLE): readValue = 32'(awakeIdle_reg);
      IDX_W'(`IDX_SLEEP_IDLE): readValue = 32'(sleepIdle_reg);
      IDX_W'(`IDX_IRQ_STATUS): readValue = 32'(irqStatus_reg);
      IDX_W'(`IDX_IRQ_MASK): readValue = 32'(irqMask_reg);
      IDX_W'(`IDX_ENGINE_STATE): begin
        readValue = {averagingCount, 11'h000, 2'h0, bootLatched_reg, inSleepState,
          state_reg};
      end
      default: readValue = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rdPend_reg) begin
      hrdata <= readValue;
    end
  end

  // reset value from boot mode pin
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rateCfg_reg <= bootModePin ? `CFG_RESET_VDD : `CFG_RESET_GND;
      bootLatched_reg <= bootModePin;
    end else if (wrPend_reg && addrIdx_reg == IDX_W'(`IDX_RATE_CFG) && !cfgLocked) begin
      rateCfg_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_reg <= '0;
    end else if (wrPend_reg && addrIdx_reg == IDX_W'(`IDX_CTRL)) begin
      ctrl_reg <= hwdata[`CTRL_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      awakeIdle_reg <= '0;
      sleepIdle_reg <= '0;
    end else if (wrPend_reg && !cfgLocked) begin
      if (addrIdx_reg == IDX_W'(`IDX_AWAKE_IDLE)) begin
        awakeIdle_reg <= hwdata[IDLE_W-1:0];
      end
      if (addrIdx_reg == IDX_W'(`IDX_SLEEP_IDLE)) begin
        sleepIdle_reg <= hwdata[IDLE_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqMask_reg <= '0;
    end else if (wrPend_reg && addrIdx_reg == IDX_W'(`IDX_IRQ_MASK)) begin
      irqMask_reg <= hwdata[`IRQ_W-1:0];
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqStatus_reg <= '0;
    end else begin
      irqStatus_reg <= (irqStatus_reg & ~((wrPend_reg &&
        addrIdx_reg == IDX_W'(`IDX_IRQ_STATUS)) ? hwdata[`IRQ_W-1:0] : '0)) |
        {switchDone, sampleStrobe};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus_reg & irqMask_reg);
    end
  end

  // Sample engine
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= sample_rate_decimation_pkg::ST_STANDBY;
      cycLeft_reg <= 32'h0000_0000;
      unitsLeft_reg <= '0;
      inSleepState <= 1'b0;
      sampleStrobe <= 1'b0;
      switchDone <= 1'b0;
    end else begin
      sampleStrobe <= 1'b0;
      switchDone <= 1'b0;
      case (state_reg)
        sample_rate_decimation_pkg::ST_STANDBY: begin
          inSleepState <= sleepRequest;
          if (active) begin
            if (selFast) begin
              state_reg <= sample_rate_decimation_pkg::ST_FIRST;
              cycLeft_reg <= FIRST_CYC - 1;
              unitsLeft_reg <= PERIOD_W'(selAvg) - 1'b1;
            end else begin
              state_reg <= sample_rate_decimation_pkg::ST_RUN;
              cycLeft_reg <= TICK_CYC - 1;
              unitsLeft_reg <= selPeriod;
            end
          end
        end
        sample_rate_decimation_pkg::ST_FIRST: begin
          if (!active) begin
            state_reg <= sample_rate_decimation_pkg::ST_STANDBY;
          end else if (sleepRequest != inSleepState) begin
            state_reg <= sample_rate_decimation_pkg::ST_GAP;
            inSleepState <= sleepRequest;
            cycLeft_reg <= GAP_CYC - 1;
          end else if (!tick) begin
            cycLeft_reg <= cycLeft_reg - 1'b1;
          end else if (unitsLeft_reg == '0) begin
            sampleStrobe <= 1'b1;
            state_reg <= sample_rate_decimation_pkg::ST_RUN;
            cycLeft_reg <= TICK_CYC - 1;
            unitsLeft_reg <= selPeriod;
          end else begin
            unitsLeft_reg <= unitsLeft_reg - 1'b1;
            cycLeft_reg <= SETTLE_CYC - 1;
          end
        end
        sample_rate_decimation_pkg::ST_RUN: begin
          if (!active) begin
            state_reg <= sample_rate_decimation_pkg::ST_STANDBY;
          end else if (sleepRequest != inSleepState) begin
            state_reg <= sample_rate_decimation_pkg::ST_GAP;
            inSleepState <= sleepRequest;
            cycLeft_reg <= GAP_CYC - 1;
          end else if (!tick) begin
            cycLeft_reg <= cycLeft_reg - 1'b1;
          end else begin
            cycLeft_reg <= TICK_CYC - 1;
            if (unitsLeft_reg <= PERIOD_W'(1)) begin
              sampleStrobe <= 1'b1;
              unitsLeft_reg <= selPeriod;
            end else begin
              unitsLeft_reg <= unitsLeft_reg - 1'b1;
            end
          end
        end
        sample_rate_decimation_pkg::ST_GAP: begin
          if (!active) begin
            state_reg <= sample_rate_decimation_pkg::ST_STANDBY;
          end else if (!tick) begin
            cycLeft_reg <= cycLeft_reg - 1'b1;
          end else begin
            sampleStrobe <= 1'b1;
            switchDone <= 1'b1;
            state_reg <= sample_rate_decimation_pkg::ST_RUN;
            cycLeft_reg <= TICK_CYC - 1;
            unitsLeft_reg <= selPeriod;
          end
        end
        default: begin
          state_reg <= sample_rate_decimation_pkg::ST_STANDBY;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      averagingCount <= '0;
    end else begin
      averagingCount <= selAvg;
    end
  end

  // ready pulse on first pin; boot mode stretches it so slow hosts see it
  low_pulse_timer #(
    .W(32)
  ) readyPulse (
    .core_clk(core_clk),
    .rst(rst),
    .start(sampleStrobe && ctrl_reg[`CTRL_READY_IRQ_EN]),
    .lengthCycles(bootLatched_reg ? PULSE_CYC : 32'h0000_0001),
    .pinLowN(firstInterruptPinN)
  );
endmodule

/* File: sample_rate_decimation_defs.svh */
// Offsets, field positions, reset values and timing counts of the rate control block
`ifndef SAMPLE_RATE_DECIMATION_DEFS_SVH
`define SAMPLE_RATE_DECIMATION_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_RATE_CFG 10'h017
`define IDX_CTRL 10'h015
`define IDX_AWAKE_IDLE 10'h018
`define IDX_SLEEP_IDLE 10'h019
`define IDX_IRQ_STATUS 10'h01A
`define IDX_IRQ_MASK 10'h01B
`define IDX_ENGINE_STATE 10'h01C

// Rate configuration fields and reset values
`define CFG_AWAKE_MSB 7
`define CFG_AWAKE_LSB 4
`define CFG_SLEEP_MSB 3
`define CFG_SLEEP_LSB 0
`define CFG_RESET_GND 8'h00
`define CFG_RESET_VDD 8'hC0

// Control fields
`define CTRL_ACTIVE 0
`define CTRL_SECOND_PIN_FUNC 1
`define CTRL_AWAKE_PM_LSB 2
`define CTRL_SLEEP_POWER_SELECT_LSB 4
`define CTRL_READY_IRQ_EN 6
`define CTRL_W 7

// Interrupt status bits
`define IRQ_SAMPLE 0
`define IRQ_SWITCH 1
`define IRQ_W 2

// Power select codes
`define PM_LOW 2'h0
`define PM_HIGH 2'h1

// Timing
`define CLK_MHZ 200
`define SAMPLE_TIME_NS 312500
`define SAMPLE_TICK_CYC (`SAMPLE_TIME_NS * `CLK_MHZ / 1000)
`define FIRST_DELAY_NS 528500
`define FIRST_DELAY_CYC ((`FIRST_DELAY_NS * `CLK_MHZ + 999) / 1000)
`define SETTLE_FACTOR_E4 9984
`define SETTLE_STEP_CYC (`SAMPLE_TICK_CYC * `SETTLE_FACTOR_E4 / 10000)
`define SWITCH_GAP_NS 500000
`define SWITCH_GAP_CYC (`SWITCH_GAP_NS * `CLK_MHZ / 1000)
`define PULSE_WIDTH_NS 5000000
`define PULSE_WIDTH_CYC (`PULSE_WIDTH_NS * `CLK_MHZ / 1000)

`endif

/* File: sample_rate_decimation_pkg.sv */
// Types of the rate control block
package sample_rate_decimation_pkg;
  typedef enum logic [3:0] {
    ST_STANDBY = 4'b0001,
    ST_FIRST = 4'b0010,
    ST_RUN = 4'b0100,
    ST_GAP = 4'b1000
  } engine_state_t;
endpackage

/* File: sample_rate_decimation_sva.sv */
// Port checker of the rate control block
`timescale 1ns/10ps
module sample_rate_decimation_sva #(
  parameter int unsigned PULSE_CYC = 5
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Engine and pin
  input wire logic sleepRequest,
  input wire logic sampleStrobe,
  input wire logic [12:0] averagingCount,
  input wire logic inSleepState,
  input wire logic firstInterruptPinN
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic take;
  int unsigned lowCnt;
  assign take = hsel && htrans[1] && hready;
  // Counts low cycles, since the pulse is far too long to unroll
  always_ff @(posedge core_clk) begin
    if (rst || firstInterruptPinN) begin
      lowCnt <= 0;
    end else begin
      lowCnt <= lowCnt + 1;
    end
  end
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  chk_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_no_wait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  chk_strobe_spacing: assert property (sampleStrobe |=> !sampleStrobe [*4])
    else $error("strobes too close");
  chk_count_pow_two: assert property ($onehot0(averagingCount))
    else $error("averaging count not a power of two");
  chk_sleep_follows: assert property ($changed(inSleepState) |-> inSleepState == $past(sleepRequest))
    else $error("state change without request");
  chk_pin_width: assert property (lowCnt <= PULSE_CYC)
    else $error("pin low too long");
  chk_pin_after_strobe: assert property ($fell(firstInterruptPinN) |-> sampleStrobe || $past(sampleStrobe))
    else $error("pin pulse without sample");
  cover property (sampleStrobe);
  cover property ($fell(firstInterruptPinN));
  cover property ($changed(inSleepState));
endmodule
bind sample_rate_decimation_ctrl sample_rate_decimation_sva #(.PULSE_CYC(PULSE_CYC)) chk (
  .core_clk(core_clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .sleepRequest(sleepRequest),
  .sampleStrobe(sampleStrobe), .averagingCount(averagingCount), .inSleepState(inSleepState),
  .firstInterruptPinN(firstInterruptPinN));

/* File: test_sample_rate_decimation_ctrl.sv */
// Self-checking bench of the rate control block
`timescale 1ns/10ps
`include "sample_rate_decimation_defs.svh"
module test_sample_rate_decimation_ctrl;
  localparam int TICK = 8;
  localparam int FIRST = 12;
  localparam int SETTLE = 6;
  localparam int GAP = 10;
  localparam int PULSE = 5;
  logic core_clk, rst, bootModePin, sleepRequest, hsel, hwrite, hreadyout, hresp;
  logic sampleStrobe, inSleepState, firstInterruptPinN, irq;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [12:0] averagingCount;
  int fails = 0;
  int n_checks = 0;
  int n;
  sample_rate_decimation_ctrl #(.TICK_CYC(TICK), .FIRST_CYC(FIRST), .SETTLE_CYC(SETTLE),
    .GAP_CYC(GAP), .PULSE_CYC(PULSE)) dut (.core_clk(core_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .bootModePin(bootModePin), .sleepRequest(sleepRequest), .sampleStrobe(sampleStrobe),
    .averagingCount(averagingCount), .inSleepState(inSleepState),
    .firstInterruptPinN(firstInterruptPinN), .irq(irq));
  ahb_host_model host (.core_clk(core_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkw(input string what, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi) begin
      fails++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    @(posedge core_clk);
    host.xfer(1'b1, idx, d, rd);
  endtask
  task automatic rdc(input string what, input logic [9:0] idx, input logic [31:0] exp);
    @(posedge core_clk);
    host.xfer(1'b0, idx, 32'h0, rd);
    chk(what, exp, rd);
  endtask
  task automatic waitStrobe(output int cnt);
    cnt = 0;
    do begin
      @(negedge core_clk);
      cnt++;
    end while (sampleStrobe !== 1'b1 && cnt < 5000);
  endtask
  task automatic doReset(input logic boot);
    @(posedge core_clk);
    rst <= 1'b1;
    bootModePin <= boot;
    sleepRequest <= 1'b0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
  endtask
  task automatic startRun(input logic [31:0] ctrl, input logic [31:0] cfg,
      input logic [31:0] idle);
    wr(`IDX_CTRL, 32'h0);
    wr(`IDX_RATE_CFG, cfg);
    wr(`IDX_AWAKE_IDLE, idle);
    wr(`IDX_SLEEP_IDLE, idle);
    wr(`IDX_CTRL, ctrl | 32'h1);
  endtask
  task automatic testRegs();
    rdc("cfg reset", `IDX_RATE_CFG, 32'h0);
    rdc("unmapped", 10'h3FF, 32'h0);
    wr(`IDX_RATE_CFG, 32'hFFFF_FFA5);
    rdc("cfg fields", `IDX_RATE_CFG, 32'hA5);
    wr(`IDX_CTRL, 32'h1);
    wr(`IDX_RATE_CFG, 32'h11);
    rdc("cfg locked", `IDX_RATE_CFG, 32'hA5);
    // Second pin function alone must hold the codes as well
    wr(`IDX_CTRL, 32'h2);
    wr(`IDX_RATE_CFG, 32'h11);
    rdc("cfg locked pin", `IDX_RATE_CFG, 32'hA5);
  endtask
  task automatic testDecode();
    int pm [7] = '{0, 0, 1, 1, 2, 3, 2};
    int code [7] = '{3, 15, 3, 14, 6, 12, 0};
    int cnt [7] = '{1, 1, 8, 4096, 64, 4096, 1};
    for (int i = 0; i < 7; i++) begin
      wr(`IDX_CTRL, 32'(pm[i]) << 2);
      wr(`IDX_RATE_CFG, 32'(code[i]) << 4);
      repeat (2) @(negedge core_clk);
      chk("avg count", 32'(cnt[i]), 32'(averagingCount));
    end
    wr(`IDX_CTRL, 32'h14);
    wr(`IDX_RATE_CFG, 32'h25);
    sleepRequest <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk("sleep state", 32'h1, 32'(inSleepState));
    chk("sleep count", 32'h20, 32'(averagingCount));
    // Count 32 at [31:19], sleep flag, boot mode clear, standby
    rdc("engine state", `IDX_ENGINE_STATE, 32'h0100_0011);
    @(posedge core_clk);
    sleepRequest <= 1'b0;
  endtask
  task automatic testPeriod();
    startRun(32'h0, 32'h10, 32'h0);
    waitStrobe(n);
    chkw("low first", 1, 2 * TICK + 2, n);
    waitStrobe(n);
    chkw("low period", 2 * TICK, 2 * TICK + 2, n);
    startRun(32'h8, 32'h0, 32'h2);
    waitStrobe(n);
    waitStrobe(n);
    chkw("flex period", 3 * TICK, 3 * TICK + 3, n);
  endtask
  task automatic testFast();
    startRun(32'h40, 32'h0, 32'h0);
    waitStrobe(n);
    chkw("fast first", FIRST, FIRST + 4, n);
    waitStrobe(n);
    chkw("fast period", TICK, TICK + 1, n);
    startRun(32'h8, 32'h10, 32'h0);
    waitStrobe(n);
    chkw("flex first", FIRST + SETTLE, FIRST + SETTLE + 5, n);
  endtask
  task automatic testGap();
    wr(`IDX_IRQ_MASK, 32'h2);
    startRun(32'h0, 32'h12, 32'h0);
    wr(`IDX_IRQ_STATUS, 32'h3);
    waitStrobe(n);
    @(posedge core_clk);
    sleepRequest <= 1'b1;
    waitStrobe(n);
    chkw("switch gap", GAP, GAP + 3, n);
    repeat (2) @(negedge core_clk);
    chk("irq switch", 32'h1, 32'(irq));
    rdc("status", `IDX_IRQ_STATUS, 32'h3);
    waitStrobe(n);
    waitStrobe(n);
    chkw("sleep period", 4 * TICK, 4 * TICK + 2, n);
    wr(`IDX_IRQ_MASK, 32'h0);
    repeat (2) @(negedge core_clk);
    chk("irq masked", 32'h0, 32'(irq));
    wr(`IDX_IRQ_MASK, 32'h2);
    wr(`IDX_IRQ_STATUS, 32'h2);
    repeat (2) @(negedge core_clk);
    chk("irq cleared", 32'h0, 32'(irq));
    @(posedge core_clk);
    sleepRequest <= 1'b0;
  endtask
  task automatic testBoot();
    doReset(1'b1);
    rdc("cfg boot", `IDX_RATE_CFG, 32'hC0);
    // Low power at 100 Hz, the fastest rate a boot mode host may pick
    startRun(32'h40, 32'h55, 32'h0);
    waitStrobe(n);
    n = 0;
    while (firstInterruptPinN !== 1'b0 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    n = 0;
    while (firstInterruptPinN === 1'b0 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    chk("pulse width", 32'(PULSE), 32'(n));
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    bootModePin = 1'b0;
    sleepRequest = 1'b0;
    doReset(1'b0);
    testRegs();
    testDecode();
    testPeriod();
    testFast();
    testGap();
    testBoot();
    results();
  end
  initial begin
    #300000;
    fails++;
    results();
  end
endmodule
